// [src/adc_clock_ref_and_sequence_ctrl.sv]
// Converter clock divider, reference select, pin muxing and conversion sequencer
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module adc_clock_ref_and_sequence_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Port logic settings
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] port_b_direction,
  input wire logic [7:0] port_a_pullup,
  input wire logic [7:0] port_b_pullup,
  // Effective pin configuration
  output logic [7:0] port_a_dir_eff,
  output logic [7:0] port_b_dir_eff,
  output logic [7:0] port_a_pullup_eff,
  output logic [7:0] port_b_pullup_eff,
  output logic [7:0] analog_pin_en,
  output logic ref_in_pin_func,
  output logic ref_out_pin_func,
  // Analog front end
  input wire logic [11:0] afe_data,
  output logic afe_power,
  output logic afe_reset,
  output logic afe_clk_en,
  output logic afe_sampling,
  output logic afe_converting,
  output logic [7:0] afe_channel,
  output logic afe_ext_chan_en,
  output logic [2:0] afe_input_src,
  output logic [1:0] afe_ref_src,
  output logic [2:0] afe_ref_gain,
  output logic afe_ref_amp_en,
  output logic afe_bandgap_en,
  output logic afe_ref_pin_connect,
  // Status
  output logic conv_busy_flag,
  output logic irq
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Reference source from the select code
  function automatic logic [1:0] ref_src_of(input logic [3:0] code);
    if (code >= 4'b0001 && code <= 4'b0100) begin
      ref_src_of = REF_PIN;
    end else if (code >= 4'b1010 && code <= 4'b1100) begin
      ref_src_of = REF_BANDGAP;
    end else begin
      ref_src_of = REF_SUPPLY;
    end
  endfunction

  // Amplifier gain 1..4; supply bypasses the amplifier
  function automatic logic [2:0] ref_gain_of(input logic [3:0] code);
    if (code >= 4'b0001 && code <= 4'b0100) begin
      ref_gain_of = code[2:0];
    end else if (code >= 4'b1010 && code <= 4'b1100) begin
      ref_gain_of = 3'(code[2:0] - 3'h0);
    end else begin
      ref_gain_of = 3'h1;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic start_reg;
  logic power_reg;
  logic align_reg;
  logic [2:0] channel_sel_reg;
  logic [2:0] input_source_sel_reg;
  logic [2:0] conv_clk_div_sel_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] analog_pin_select_bits_reg;
  logic [7:0] int_mask_reg;
  logic int_done_reg;
  logic [11:0] result_reg;
  seq_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [6:0] presc_reg;
  logic [11:0] data_s1_reg;
  logic [11:0] data_s2_reg;
  logic tick;
  logic launch;
  logic conv_done;
  logic wr_c0;

  assign wr_c0 = reg_wr && (reg_addr == OFS_CONV_CONTROL_0);

  // Software controls; the start bit is plain storage, edges decoded below
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start_reg <= 1'b0;
      power_reg <= 1'b0;
      align_reg <= 1'b0;
      channel_sel_reg <= 3'h0;
      input_source_sel_reg <= 3'h0;
      conv_clk_div_sel_reg <= 3'h0;
      ctrl2_reg <= RST_CTRL;
      analog_pin_select_bits_reg <= RST_ANALOG_PIN_SEL;
      int_mask_reg <= RST_CTRL;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CONV_CONTROL_0) begin
        start_reg <= reg_wdata[C0_START];
        power_reg <= reg_wdata[C0_POWER];
        align_reg <= reg_wdata[C0_ALIGN];
        channel_sel_reg <= reg_wdata[2:0];
      end else if (reg_addr == OFS_CONV_CONTROL_1) begin
        input_source_sel_reg <= reg_wdata[C1_SRC_LSB +: 3];
        conv_clk_div_sel_reg <= reg_wdata[2:0];
      end else if (reg_addr == OFS_CONV_CONTROL_2) begin
        ctrl2_reg <= reg_wdata;
      end else if (reg_addr == OFS_ANALOG_PIN_SEL) begin
        analog_pin_select_bits_reg <= reg_wdata;
      end else if (reg_addr == OFS_INT_MASK) begin
        int_mask_reg <= reg_wdata;
      end
    end
  end

  // Start edges: high-to-low after high launches, low-to-high resets
  assign launch = wr_c0 && start_reg && !reg_wdata[C0_START] && power_reg;
  logic start_rise;
  assign start_rise = wr_c0 && !start_reg && reg_wdata[C0_START];

  // Read mux, data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == OFS_CONV_CONTROL_0) begin
        reg_rdata <= {start_reg, conv_busy_flag, power_reg, align_reg, 1'b0, channel_sel_reg};
      end else if (reg_addr == OFS_CONV_CONTROL_1) begin
        reg_rdata <= {input_source_sel_reg, 2'b00, conv_clk_div_sel_reg};
      end else if (reg_addr == OFS_CONV_CONTROL_2) begin
        reg_rdata <= ctrl2_reg;
      end else if (reg_addr == OFS_ANALOG_PIN_SEL) begin
        reg_rdata <= analog_pin_select_bits_reg;
      end else if (reg_addr == OFS_RESULT_HIGH) begin
        reg_rdata <= align_reg ? {4'h0, result_reg[11:8]} : result_reg[11:4];
      end else if (reg_addr == OFS_RESULT_LOW) begin
        reg_rdata <= align_reg ? result_reg[7:0] : {result_reg[3:0], 4'h0};
      end else if (reg_addr == OFS_INT_STATUS) begin
        reg_rdata <= {7'h00, int_done_reg};
      end else if (reg_addr == OFS_INT_MASK) begin
        reg_rdata <= int_mask_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------------
  // Prescaler restarts at launch so the first sample clock has a full period
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_reg <= 7'h00;
    end else if (launch || start_rise || !power_reg) begin
      presc_reg <= 7'h00;
    end else begin
      presc_reg <= 7'(presc_reg + 7'h01);
    end
  end

  logic [6:0] div_mask;
  assign div_mask = 7'((8'h01 << conv_clk_div_sel_reg) - 8'h01);
  assign tick = ((presc_reg & div_mask) == div_mask);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Runs on its own after launch; the register port is never stalled
  // Gated like the sequencer so an abort or relaunch in the last clock raises no status
  assign conv_done = (state_reg == ST_CONVERT) && tick && power_reg && !start_rise && !launch
    && (cnt_reg == 4'(CONVERT_CLKS - 4'h1));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
    end else if (!power_reg) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
    end else if (start_rise) begin
      state_reg <= ST_HOLD;
      cnt_reg <= 4'h0;
    end else if (launch) begin
      state_reg <= ST_SAMPLE;
      cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_SAMPLE: begin
          if (tick) begin
            if (cnt_reg == 4'(SAMPLE_CLKS - 4'h1)) begin
              state_reg <= ST_CONVERT;
              cnt_reg <= 4'h0;
            end else begin
              cnt_reg <= 4'(cnt_reg + 4'h1);
            end
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
          end else if (tick) begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end
        end
        ST_HOLD: begin
          state_reg <= ST_HOLD;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Front end word passes two flops; it is stable by the last convert clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_s1_reg <= 12'h000;
      data_s2_reg <= 12'h000;
    end else begin
      data_s1_reg <= afe_data;
      data_s2_reg <= data_s1_reg;
    end
  end

  // Result is cleared while the converter is powered down
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_reg <= 12'h000;
    end else if (!power_reg) begin
      result_reg <= 12'h000;
    end else if (conv_done) begin
      result_reg <= data_s2_reg;
    end
  end

  // Busy flag and completion event; a new done beats a same-cycle clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_busy_flag <= 1'b0;
      int_done_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (launch) begin
        conv_busy_flag <= 1'b1;
      end else if (conv_done || start_rise || !power_reg) begin
        conv_busy_flag <= 1'b0;
      end
      if (conv_done) begin
        int_done_reg <= 1'b1;
      end else if (reg_wr && reg_addr == OFS_INT_STATUS && reg_wdata[INT_DONE]) begin
        int_done_reg <= 1'b0;
      end
      irq <= int_done_reg && int_mask_reg[INT_DONE];
    end
  end

  // ----------------------------------------------------------------------
  // Front end controls, reference and pins
  // ----------------------------------------------------------------------
  logic [1:0] code_src;
  logic bg_en;
  logic ext_sel;
  assign code_src = ref_src_of(ctrl2_reg[3:0]);
  assign bg_en = ctrl2_reg[C2_BG_EN];
  assign ext_sel = (input_source_sel_reg == SRC_EXT_A) || (input_source_sel_reg == SRC_EXT_B);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      afe_power <= 1'b0;
      afe_reset <= 1'b1;
      afe_clk_en <= 1'b0;
      afe_sampling <= 1'b0;
      afe_converting <= 1'b0;
      afe_channel <= 8'h00;
      afe_ext_chan_en <= 1'b0;
      afe_input_src <= 3'h0;
      afe_ref_src <= REF_SUPPLY;
      afe_ref_gain <= 3'h1;
      afe_ref_amp_en <= 1'b0;
      afe_bandgap_en <= 1'b0;
      afe_ref_pin_connect <= 1'b0;
      ref_in_pin_func <= 1'b0;
      ref_out_pin_func <= 1'b0;
    end else begin
      afe_power <= power_reg;
      afe_reset <= !power_reg || (state_reg == ST_HOLD);
      afe_clk_en <= tick && (state_reg == ST_SAMPLE || state_reg == ST_CONVERT);
      afe_sampling <= (state_reg == ST_SAMPLE);
      afe_converting <= (state_reg == ST_CONVERT);
      afe_channel <= ext_sel ? 8'(8'h01 << channel_sel_reg) : 8'h00;
      afe_ext_chan_en <= ext_sel;
      afe_input_src <= input_source_sel_reg;
      // Pin code with bandgap also enabled falls to the bandgap alone
      afe_ref_src <= (code_src == REF_PIN && bg_en) ? REF_BANDGAP : code_src;
      afe_ref_gain <= ref_gain_of(ctrl2_reg[3:0]);
      afe_ref_amp_en <= ctrl2_reg[C2_AMP_EN];
      afe_bandgap_en <= bg_en;
      afe_ref_pin_connect <= (code_src == REF_PIN) && !bg_en && ctrl2_reg[C2_REF_IN];
      ref_in_pin_func <= ctrl2_reg[C2_REF_IN];
      ref_out_pin_func <= ctrl2_reg[C2_REF_OUT];
    end
  end

  // Pin map: bits 0-2 and 7 on port B 0-3, bits 3-6 on port A 4-7
  logic [7:0] sel_a;
  logic [7:0] sel_b;
  assign sel_a = {analog_pin_select_bits_reg[6:3], 4'h0};
  assign sel_b = {4'h0, analog_pin_select_bits_reg[7], analog_pin_select_bits_reg[2:0]};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_dir_eff <= 8'hFF;
      port_b_dir_eff <= 8'hFF;
      port_a_pullup_eff <= 8'h00;
      port_b_pullup_eff <= 8'h00;
      analog_pin_en <= 8'h00;
    end else begin
      port_a_dir_eff <= port_a_direction | sel_a;
      port_b_dir_eff <= port_b_direction | sel_b;
      port_a_pullup_eff <= port_a_pullup & ~sel_a;
      port_b_pullup_eff <= port_b_pullup & ~sel_b;
      analog_pin_en <= analog_pin_select_bits_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_last_sample;
    state_reg == ST_SAMPLE && tick && cnt_reg == 4'h3 && power_reg && !start_rise && !launch;
  endsequence
  sequence s_in_convert;
    state_reg == ST_CONVERT && cnt_reg == 4'h0;
  endsequence

  AST_BUSY_LAUNCH: assert property (launch |=> conv_busy_flag)
    else $error("busy not set after launch");
  AST_DONE_EVENT: assert property (conv_done |=> !conv_busy_flag && int_done_reg ##1 irq == int_mask_reg[0])
    else $error("done did not clear busy and set status");
  AST_HOLD_RESET: assert property (start_rise && power_reg |=> state_reg == ST_HOLD && !conv_busy_flag ##1 afe_reset)
    else $error("start held high did not reset converter");
  AST_DIV_BY_TWO: assert property (conv_clk_div_sel_reg == 3'h1 && tick && !reg_wr |=> !tick)
    else $error("divide by two ticked twice in a row");
  AST_SAMPLE_LEN: assert property (s_last_sample |=> s_in_convert)
    else $error("sampling phase length wrong");
  AST_FIRST_SAMPLE: assert property (launch |=> state_reg == ST_SAMPLE && cnt_reg == 4'h0 && presc_reg == 7'h00)
    else $error("launch did not restart sample phase");
  AST_PULLUP_OFF: assert property (analog_pin_select_bits_reg[0] |=> !port_b_pullup_eff[0])
    else $error("pull-up left on for analog pin");
  AST_DIR_OVERRIDE: assert property (analog_pin_select_bits_reg[3] |=> port_a_dir_eff[4])
    else $error("direction not overridden for analog pin");
  AST_BG_PRIORITY: assert property (code_src == REF_PIN && bg_en |=> afe_ref_src == REF_BANDGAP && !afe_ref_pin_connect)
    else $error("pin reference used with bandgap requested");
  AST_EXT_OFF: assert property (!ext_sel |=> !afe_ext_chan_en && afe_channel == 8'h00)
    else $error("external channel connected with internal source");
  AST_POWER_OFF: assert property (!power_reg |=> state_reg == ST_IDLE && result_reg == 12'h000)
    else $error("converter active while powered down");
endmodule

// [src/adc_ctrl_pkg.sv]
// Shared constants for the converter clock, reference and sequence control
package adc_ctrl_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] OFS_CONV_CONTROL_0 = 3'h0;
  localparam logic [2:0] OFS_CONV_CONTROL_1 = 3'h1;
  localparam logic [2:0] OFS_CONV_CONTROL_2 = 3'h2;
  localparam logic [2:0] OFS_ANALOG_PIN_SEL = 3'h3;
  localparam logic [2:0] OFS_RESULT_HIGH = 3'h4;
  localparam logic [2:0] OFS_RESULT_LOW = 3'h5;
  localparam logic [2:0] OFS_INT_STATUS = 3'h6;
  localparam logic [2:0] OFS_INT_MASK = 3'h7;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int C0_START = 7;
  localparam int C0_BUSY = 6;
  localparam int C0_POWER = 5;
  localparam int C0_ALIGN = 4;
  localparam int C1_SRC_LSB = 5;
  localparam int C2_AMP_EN = 7;
  localparam int C2_BG_EN = 6;
  localparam int C2_REF_IN = 5;
  localparam int C2_REF_OUT = 4;
  localparam int INT_DONE = 0;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_ANALOG_PIN_SEL = 8'hFF;
  // ----------------------------------------------------------------------
  // Sequence timing in conversion clocks
  // ----------------------------------------------------------------------
  localparam logic [3:0] SAMPLE_CLKS = 4'h4;
  localparam logic [3:0] CONVERT_CLKS = 4'hC;
  // ----------------------------------------------------------------------
  // Reference, input source and sequencer state decode
  // ----------------------------------------------------------------------
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h1;
  localparam logic [1:0] REF_BANDGAP = 2'h2;
  localparam logic [2:0] SRC_EXT_A = 3'h0;
  localparam logic [2:0] SRC_EXT_B = 3'h4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONVERT = 2'b11
  } seq_state_t;
endpackage

// [verif/adc_clock_ref_and_sequence_ctrl_tb.sv]
// Self-checking bench for the converter clock, reference and sequence control
`timescale 1ns/10ps
module adc_clock_ref_and_sequence_ctrl_tb;
  import adc_ctrl_pkg::*;
  logic core_clk, resetn, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, analog_pin_en, afe_channel;
  logic [7:0] port_a_direction, port_b_direction, port_a_pullup, port_b_pullup;
  logic [7:0] port_a_dir_eff, port_b_dir_eff, port_a_pullup_eff, port_b_pullup_eff;
  logic ref_in_pin_func, ref_out_pin_func, afe_power, afe_reset, afe_clk_en;
  logic afe_sampling, afe_converting, afe_ext_chan_en, afe_ref_amp_en, afe_bandgap_en;
  logic afe_ref_pin_connect, conv_busy_flag, irq;
  logic [11:0] afe_data, dw;
  logic [2:0] afe_input_src, afe_ref_gain, eg, src, ch;
  logic [1:0] afe_ref_src, es;
  logic [7:0] sel, am, bm;
  logic [7:0] sels [4] = '{8'hFF, 8'h0F, 8'h80, 8'h00};
  int err_count, n_checks, nb, ns, nk, nc;

  adc_clock_ref_and_sequence_ctrl i_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .port_a_pullup(port_a_pullup), .port_b_pullup(port_b_pullup),
    .port_a_dir_eff(port_a_dir_eff), .port_b_dir_eff(port_b_dir_eff),
    .port_a_pullup_eff(port_a_pullup_eff), .port_b_pullup_eff(port_b_pullup_eff),
    .analog_pin_en(analog_pin_en), .ref_in_pin_func(ref_in_pin_func),
    .ref_out_pin_func(ref_out_pin_func), .afe_data(afe_data), .afe_power(afe_power),
    .afe_reset(afe_reset), .afe_clk_en(afe_clk_en), .afe_sampling(afe_sampling),
    .afe_converting(afe_converting), .afe_channel(afe_channel),
    .afe_ext_chan_en(afe_ext_chan_en), .afe_input_src(afe_input_src),
    .afe_ref_src(afe_ref_src), .afe_ref_gain(afe_ref_gain), .afe_ref_amp_en(afe_ref_amp_en),
    .afe_bandgap_en(afe_bandgap_en), .afe_ref_pin_connect(afe_ref_pin_connect),
    .conv_busy_flag(conv_busy_flag), .irq(irq)
  );

  afe_model i_afe (
    .core_clk(core_clk), .afe_power(afe_power), .afe_reset(afe_reset),
    .afe_sampling(afe_sampling), .afe_channel(afe_channel), .afe_data(afe_data)
  );

  // ----------------------------------------------------------------------
  // Clock, bus tasks and comparison
  // ----------------------------------------------------------------------
  // Free-running system clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Strobe waits one edge before rising, so back-to-back calls never double-drive
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the longest divider sweep
  initial begin
    #100000;
    err_count++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    err_count = 0;
    n_checks = 0;
    resetn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    port_a_direction = 8'h05;
    port_b_direction = 8'h30;
    port_a_pullup = 8'hFF;
    port_b_pullup = 8'hDF;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rchk(a[2:0], (a == 3) ? 8'hFF : 8'h00);
    end
    // Pin takeover: all, a mix, only the last mapped pin, none
    foreach (sels[i]) begin
      sel = sels[i];
      am = {sel[6:3], 4'h0};
      bm = {4'h0, sel[7], sel[2:0]};
      wr(OFS_ANALOG_PIN_SEL, sel);
      settle(2);
      chk(analog_pin_en, sel);
      chk(port_a_dir_eff, am | port_a_direction);
      chk(port_b_dir_eff, bm | port_b_direction);
      chk(port_a_pullup_eff, ~am & port_a_pullup);
      chk(port_b_pullup_eff, ~bm & port_b_pullup);
    end
    // Every reference code, amplifier and both pin functions on
    for (int c = 0; c < 16; c++) begin
      wr(OFS_CONV_CONTROL_2, {4'hB, c[3:0]});
      settle(2);
      es = REF_SUPPLY;
      eg = 3'h1;
      if (c >= 1 && c <= 4) begin
        es = REF_PIN;
        eg = c[2:0];
      end
      if (c >= 10 && c <= 12) begin
        es = REF_BANDGAP;
        eg = c[2:0];
      end
      chk(afe_ref_src, es);
      chk(afe_ref_gain, eg);
      chk(afe_ref_pin_connect, es == REF_PIN);
      chk({ref_in_pin_func, ref_out_pin_func, afe_ref_amp_en}, 3'h7);
    end
    wr(OFS_CONV_CONTROL_2, 8'hF2);
    settle(2);
    chk({afe_ref_src, afe_ref_gain, afe_ref_pin_connect, afe_bandgap_en}, 7'h49);
    wr(OFS_CONV_CONTROL_2, 8'h00);
    settle(2);
    chk({ref_in_pin_func, ref_out_pin_func}, 2'b00);
    // Start pulse is ignored while the converter is unpowered
    wr(OFS_CONV_CONTROL_0, 8'h80);
    wr(OFS_CONV_CONTROL_0, 8'h00);
    settle(4);
    chk(conv_busy_flag, 1'b0);
    wr(OFS_INT_MASK, 8'hA5);
    rchk(OFS_INT_MASK, 8'hA5);
    wr(OFS_CONV_CONTROL_0, 8'h20);
    settle(20);
    // Divider sweep; one code uses an internal source, one keeps the interrupt masked
    for (int d = 0; d < 8; d++) begin
      src = (d == 5) ? 3'h2 : (d[0] ? SRC_EXT_B : SRC_EXT_A);
      ch = 3'(7 - d);
      wr(OFS_INT_MASK, {7'h00, d != 3});
      wr(OFS_CONV_CONTROL_1, {src, 2'b00, d[2:0]});
      wr(OFS_CONV_CONTROL_0, {3'b101, d[1], 1'b0, ch});
      settle(2);
      chk({conv_busy_flag, afe_reset}, 2'b01);
      chk(afe_ext_chan_en, src != 3'h2);
      chk(afe_input_src, src);
      chk(afe_channel, (src == 3'h2) ? 8'h00 : (8'h01 << ch));
      wr(OFS_CONV_CONTROL_0, {3'b001, d[1], 1'b0, ch});
      nb = 0;
      ns = 0;
      nk = 0;
      nc = 0;
      repeat ((16 << d) + 8) begin
        settle(1);
        nb += int'(conv_busy_flag === 1'b1);
        ns += int'(afe_sampling === 1'b1);
        nk += int'(afe_clk_en === 1'b1);
        nc += int'(afe_converting === 1'b1);
      end
      chk(nb >= (16 << d) - 2 && nb <= (16 << d) + 2, 1'b1);
      chk(ns >= (4 << d) - 2 && ns <= (4 << d) + 2, 1'b1);
      chk(nc >= (12 << d) - 2 && nc <= (12 << d) + 2, 1'b1);
      chk(nk, 16);
      chk({conv_busy_flag, irq}, {1'b0, d != 3});
      dw = (src == 3'h2) ? 12'hA00 : {4'hA, 8'h01 << ch};
      rchk(OFS_RESULT_HIGH, d[1] ? {4'h0, dw[11:8]} : dw[11:4]);
      rchk(OFS_RESULT_LOW, d[1] ? dw[7:0] : {dw[3:0], 4'h0});
      rchk(OFS_INT_STATUS, 8'h01);
      wr(OFS_INT_STATUS, 8'h01);
      rchk(OFS_INT_STATUS, 8'h00);
      chk(irq, 1'b0);
    end
    // Mid-conversion: busy readable, start held high aborts, power off clears
    wr(OFS_CONV_CONTROL_1, 8'h03);
    wr(OFS_CONV_CONTROL_0, 8'hA0);
    wr(OFS_CONV_CONTROL_0, 8'h20);
    settle(20);
    rchk(OFS_CONV_CONTROL_0, 8'h60);
    wr(OFS_CONV_CONTROL_0, 8'hA0);
    settle(2);
    chk({conv_busy_flag, afe_reset}, 2'b01);
    settle(150);
    rchk(OFS_INT_STATUS, 8'h00);
    wr(OFS_CONV_CONTROL_0, 8'h20);
    settle(10);
    wr(OFS_CONV_CONTROL_0, 8'h00);
    settle(2);
    chk({conv_busy_flag, afe_power, afe_reset}, 3'b001);
    rchk(OFS_RESULT_HIGH, 8'h00);
    rchk(OFS_INT_STATUS, 8'h00);
    final_report();
  end
endmodule

// [verif/afe_model.sv]
// Behavioural analog front end answering each conversion with a channel-tagged word
`timescale 1ns/10ps
module afe_model (
  // Clock
  input wire logic core_clk,
  // Control from the converter logic
  input wire logic afe_power,
  input wire logic afe_reset,
  input wire logic afe_sampling,
  input wire logic [7:0] afe_channel,
  // Result word
  output logic [11:0] afe_data
);
  logic samp_d;
  // ----------------------------------------------------------------------
  // Conversion word
  // ----------------------------------------------------------------------
  // Unpowered or held in reset the word churns, so a stale capture cannot pass
  initial begin
    afe_data = 12'h000;
    samp_d = 1'b0;
  end
  // Word is frozen from the start of sampling until the next conversion
  always @(posedge core_clk) begin
    samp_d <= afe_sampling;
    if (!afe_power || afe_reset) begin
      afe_data <= ~afe_data;
    end else if (afe_sampling && !samp_d) begin
      afe_data <= {4'hA, afe_channel};
    end
  end
endmodule
